// File: src/lcd_driver_config.sv
// Purpose: Configuration state and RAM write pointers of an LCD row and
//          column driver, reached by software over APB.
// Assumes: One 20 MHz clock; rst_b_i is asynchronous and active low.
// Notes:   Zero wait states; read data is captured in the setup cycle.
// Notes on behaviour
// - Power-down grounds outputs, stops oscillator, keeps reset detection.
// - In power-down the register port still takes and executes commands.
// - Power-down never clears RAM; data writes still reach the RAM.
// - Entering or leaving power-down changes no configuration field.
// - Direction flag clear: each data byte advances the column pointer.
// - Direction flag set: each data byte outside bank 5 advances the bank pointer.
// - Bank 5 icon writes behave the same in either direction.
// - Three-bit bank pointer selects banks 0 to 5; 101 is icons.
// - Column pointer covers 0 to 127 and maps straight onto columns.
// - Multiplex field: 00 gives 1:17, 10 gives 1:26, 01 gives 1:34.
// - Two display-mode bits select blank, normal or other presentation.
// - Icon-mode bit switches the display to icons only.
// - Bias factor n is seven minus the three-bit bias field.
// - Drive voltage is 2.94 V or 6.75 V plus code times 30 mV.
// - Reset sets the voltage multiplier to two times the supply.
// - Two-bit multiplier field selects the multiplier factor.
// - Reset sets power-down, horizontal mode and zeroes other fields.
// - Horizontal wrap: column 127 goes to 0 and bank advances, 4 to 0.
`timescale 1ns/1ps
`default_nettype none

module lcd_driver_config
   import lcd_cfg_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             lcd_grounded_o,
   output logic             osc_enable_o,
   output logic             por_detect_enable_o,
   output logic             ram_we_o,
   output logic      [6:0]  ram_col_o,
   output logic      [2:0]  ram_bank_o,
   output logic      [7:0]  ram_data_o,
   output logic      [5:0]  mux_duty_o,
   output logic      [1:0]  display_mode_o,
   output logic             icon_only_o,
   output logic      [2:0]  bias_n_o,
   output logic      [2:0]  temp_coefficient_o,
   output logic      [2:0]  multiplier_factor_o,
   output logic             hv_enable_o,
   output logic      [13:0] drive_mv_o,
   output logic      [1:0]  cmd_page_o
);
   import lcd_cfg_pkg::*;

   logic        rst_meta_reg;
   logic        rst_n;
   logic        power_down_flag_reg, power_down_flag_next;
   logic        vertical_reg,        vertical_next;
   logic [1:0]  display_mode_reg,    display_mode_next;
   logic        icon_only_flag_reg,  icon_only_flag_next;
   logic [1:0]  mux_reg,             mux_next;
   logic [2:0]  bias_factor_field_reg, bias_factor_field_next;
   logic [2:0]  temp_coefficient_field_reg, temp_coefficient_field_next;
   logic [1:0]  mult_reg,            mult_next;
   logic        hv_generator_enable_reg, hv_generator_enable_next;
   logic        voltage_range_select_reg, voltage_range_select_next;
   logic [1:0]  page_reg,            page_next;
   logic [6:0]  drive_voltage_value_reg, drive_voltage_value_next;
   logic [6:0]  col_reg,             col_next;
   logic [2:0]  bank_pointer_reg,    bank_pointer_next;
   logic        we_reg,              we_next;
   logic [6:0]  wcol_reg,            wcol_next;
   logic [2:0]  wbank_reg,           wbank_next;
   logic [7:0]  wdata_reg,           wdata_next;
   logic [31:0] rdata_reg,           rdata_next;
   logic        err_reg,             err_next;
   logic        setup;
   logic        wr_acc;
   logic        mapped;
   logic [31:0] ctrl_word;
   logic [31:0] cfg_word;
   logic [31:0] ptr_word;
   logic [31:0] stat_word;

   // Reset is released through two flops so that removal is synchronous.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // Bus decode; the slave never inserts wait states.
   assign setup    = psel_i && !penable_i;
   assign wr_acc   = psel_i && penable_i && pwrite_i;
   assign mapped   = (paddr_i == CTRL_OFS) || (paddr_i == CFG_OFS) ||
                     (paddr_i == VOLT_OFS) || (paddr_i == PTR_OFS) ||
                     (paddr_i == DATA_OFS) || (paddr_i == STAT_OFS);
   assign pready_o  = 1'b1;
   assign pslverr_o = err_reg;
   assign prdata_o  = rdata_reg;

   // Readback words assembled from the live field registers.
   always_comb
   begin
      ctrl_word = 32'h0;
      ctrl_word[PD_BIT]              = power_down_flag_reg;
      ctrl_word[VERT_BIT]            = vertical_reg;
      ctrl_word[DISP_LSB +: 2]       = display_mode_reg;
      ctrl_word[ICON_BIT]            = icon_only_flag_reg;
      cfg_word = 32'h0;
      cfg_word[MUX_LSB +: 2]         = mux_reg;
      cfg_word[BIAS_LSB +: 3]        = bias_factor_field_reg;
      cfg_word[TC_LSB +: 3]          = temp_coefficient_field_reg;
      cfg_word[MULT_LSB +: 2]        = mult_reg;
      cfg_word[HVE_BIT]              = hv_generator_enable_reg;
      cfg_word[PRS_BIT]              = voltage_range_select_reg;
      cfg_word[PAGE_LSB +: 2]        = page_reg;
      ptr_word = 32'h0;
      ptr_word[COL_LSB +: 7]         = col_reg;
      ptr_word[BANK_LSB +: 3]        = bank_pointer_reg;
      stat_word = 32'h0;
      stat_word[0]                   = osc_enable_o;
      stat_word[1]                   = lcd_grounded_o;
      stat_word[4:2]                 = multiplier_factor_o;
      stat_word[7:5]                 = bias_n_o;
      stat_word[13:8]                = mux_duty_o;
   end

   // Next state of every field, pointer and bus answer register.
   always_comb
   begin
      power_down_flag_next        = power_down_flag_reg;
      vertical_next               = vertical_reg;
      display_mode_next           = display_mode_reg;
      icon_only_flag_next         = icon_only_flag_reg;
      mux_next                    = mux_reg;
      bias_factor_field_next      = bias_factor_field_reg;
      temp_coefficient_field_next = temp_coefficient_field_reg;
      mult_next                   = mult_reg;
      hv_generator_enable_next    = hv_generator_enable_reg;
      voltage_range_select_next   = voltage_range_select_reg;
      page_next                   = page_reg;
      drive_voltage_value_next    = drive_voltage_value_reg;
      col_next                    = col_reg;
      bank_pointer_next           = bank_pointer_reg;
      we_next                     = 1'b0;
      wcol_next                   = wcol_reg;
      wbank_next                  = wbank_reg;
      wdata_next                  = wdata_reg;
      rdata_next                  = rdata_reg;
      err_next                    = err_reg;
      // Read data and error are settled in setup so outputs come from flops.
      if (setup)
      begin
         err_next   = !mapped;
         rdata_next = 32'h0;
         case (paddr_i)
            CTRL_OFS: rdata_next = ctrl_word;
            CFG_OFS:  rdata_next = cfg_word;
            VOLT_OFS: rdata_next = {25'h0, drive_voltage_value_reg};
            PTR_OFS:  rdata_next = ptr_word;
            STAT_OFS: rdata_next = stat_word;
            default:  rdata_next = 32'h0;
         endcase
      end
      // Writes are taken whatever the power state.
      if (wr_acc)
      begin
         case (paddr_i)
            CTRL_OFS:
            begin
               power_down_flag_next = pwdata_i[PD_BIT];
               vertical_next        = pwdata_i[VERT_BIT];
               display_mode_next    = pwdata_i[DISP_LSB +: 2];
               icon_only_flag_next  = pwdata_i[ICON_BIT];
            end
            CFG_OFS:
            begin
               mux_next                    = pwdata_i[MUX_LSB +: 2];
               bias_factor_field_next      = pwdata_i[BIAS_LSB +: 3];
               temp_coefficient_field_next = pwdata_i[TC_LSB +: 3];
               mult_next                   = pwdata_i[MULT_LSB +: 2];
               hv_generator_enable_next    = pwdata_i[HVE_BIT];
               voltage_range_select_next   = pwdata_i[PRS_BIT];
               page_next                   = pwdata_i[PAGE_LSB +: 2];
            end
            VOLT_OFS: drive_voltage_value_next = pwdata_i[6:0];
            PTR_OFS:
            begin
               col_next = pwdata_i[COL_LSB +: 7];
               // Banks 6 and 7 do not exist, so such a write leaves it.
               if (pwdata_i[BANK_LSB +: 3] <= BANK_ICON)
               begin
                  bank_pointer_next = pwdata_i[BANK_LSB +: 3];
               end
            end
            DATA_OFS:
            begin
               // RAM writes go out even in power-down.
               we_next    = 1'b1;
               wcol_next  = col_reg;
               wbank_next = bank_pointer_reg;
               wdata_next = pwdata_i[7:0];
               if (bank_pointer_reg == BANK_ICON)
               begin
                  // Icon bank ignores the direction flag.
                  col_next = col_reg + 7'h1;
               end
               else if (!vertical_reg)
               begin
                  // Horizontal: column first, then bank.
                  col_next = col_reg + 7'h1;
                  if (col_reg == COL_LAST)
                  begin
                     bank_pointer_next = (bank_pointer_reg == BANK_LAST) ?
                                         3'h0 : bank_pointer_reg + 3'h1;
                  end
               end
               else
               begin
                  // Vertical: bank first, then column.
                  bank_pointer_next = bank_pointer_reg + 3'h1;
                  if (bank_pointer_reg == BANK_LAST)
                  begin
                     bank_pointer_next = 3'h0;
                     col_next          = col_reg + 7'h1;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // Field registers; reset defaults put the driver in power-down.
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         power_down_flag_reg        <= PD_RST;
         vertical_reg               <= 1'b0;
         display_mode_reg           <= 2'h0;
         icon_only_flag_reg         <= 1'b0;
         mux_reg                    <= MUX_17;
         bias_factor_field_reg      <= 3'h0;
         temp_coefficient_field_reg <= 3'h0;
         mult_reg                   <= 2'h0;
         hv_generator_enable_reg    <= 1'b0;
         voltage_range_select_reg   <= 1'b0;
         page_reg                   <= 2'h0;
         drive_voltage_value_reg    <= VOLT_RST;
         col_reg                    <= 7'h0;
         bank_pointer_reg           <= 3'h0;
         we_reg                     <= 1'b0;
         wcol_reg                   <= 7'h0;
         wbank_reg                  <= 3'h0;
         wdata_reg                  <= 8'h0;
         rdata_reg                  <= 32'h0;
         err_reg                    <= 1'b0;
      end
      else
      begin
         power_down_flag_reg        <= power_down_flag_next;
         vertical_reg               <= vertical_next;
         display_mode_reg           <= display_mode_next;
         icon_only_flag_reg         <= icon_only_flag_next;
         mux_reg                    <= mux_next;
         bias_factor_field_reg      <= bias_factor_field_next;
         temp_coefficient_field_reg <= temp_coefficient_field_next;
         mult_reg                   <= mult_next;
         hv_generator_enable_reg    <= hv_generator_enable_next;
         voltage_range_select_reg   <= voltage_range_select_next;
         page_reg                   <= page_next;
         drive_voltage_value_reg    <= drive_voltage_value_next;
         col_reg                    <= col_next;
         bank_pointer_reg           <= bank_pointer_next;
         we_reg                     <= we_next;
         wcol_reg                   <= wcol_next;
         wbank_reg                  <= wbank_next;
         wdata_reg                  <= wdata_next;
         rdata_reg                  <= rdata_next;
         err_reg                    <= err_next;
      end
   end

   // Power-down grounds the outputs and stops the oscillator, but reset
   // detection must stay armed so a supply dip is still caught.
   // Only outputs are gated, so every field keeps its value.
   assign lcd_grounded_o      = power_down_flag_reg;
   assign osc_enable_o        = !power_down_flag_reg;
   assign por_detect_enable_o = 1'b1;
   assign ram_we_o            = we_reg;
   assign ram_col_o           = wcol_reg;
   assign ram_bank_o          = wbank_reg;
   assign ram_data_o          = wdata_reg;
   assign display_mode_o      = display_mode_reg;
   assign icon_only_o         = icon_only_flag_reg;
   assign temp_coefficient_o  = temp_coefficient_field_reg;
   assign hv_enable_o         = hv_generator_enable_reg;
   assign cmd_page_o          = page_reg;
   assign bias_n_o            = BIAS_TOP - bias_factor_field_reg;
   // Field zero is two times the supply, up to five.
   assign multiplier_factor_o = MULT_BASE + {1'b0, mult_reg};

   // Duty decode; the unused code 11 falls back to the lowest rate.
   always_comb
   begin
      case (mux_reg)
         MUX_26:  mux_duty_o = DUTY_26;
         MUX_34:  mux_duty_o = DUTY_34;
         default: mux_duty_o = DUTY_17;
      endcase
   end

   // Generator off means zero volts; the product is widened before adding.
   // Range limits are not enforced here, the host owns the 9 V ceiling.
   always_comb
   begin
      drive_mv_o = 14'h0;
      if (hv_generator_enable_reg)
      begin
         drive_mv_o = (voltage_range_select_reg ? VHI_MV : VLO_MV) +
                      (14'(drive_voltage_value_reg) * 14'(VSTEP_MV));
      end
   end

   // Checks on the behaviour above.
   property p_pd_ground;
      @(posedge clk_i) disable iff (!rst_n)
      power_down_flag_reg |-> lcd_grounded_o && !osc_enable_o &&
                              por_detect_enable_o;
   endproperty
   a_pd_ground: assert property (p_pd_ground)
      else $error("power-down did not ground outputs");

   property p_pd_cmd;
      @(posedge clk_i) disable iff (!rst_n)
      (power_down_flag_reg && wr_acc && paddr_i == VOLT_OFS) |=>
         drive_voltage_value_reg == $past(pwdata_i[6:0]);
   endproperty
   a_pd_cmd: assert property (p_pd_cmd)
      else $error("command lost during power-down");

   property p_pd_ram;
      @(posedge clk_i) disable iff (!rst_n)
      (wr_acc && paddr_i == DATA_OFS) |=>
         ram_we_o && ram_data_o == $past(pwdata_i[7:0]) &&
         ram_col_o == $past(col_reg) &&
         ram_bank_o == $past(bank_pointer_reg);
   endproperty
   a_pd_ram: assert property (p_pd_ram)
      else $error("data write did not reach RAM");

   property p_pd_keep;
      @(posedge clk_i) disable iff (!rst_n)
      (wr_acc && paddr_i == CTRL_OFS &&
       pwdata_i[PD_BIT] != power_down_flag_reg) |=>
         $stable(cfg_word) && $stable(ptr_word) &&
         $stable(drive_voltage_value_reg);
   endproperty
   a_pd_keep: assert property (p_pd_keep)
      else $error("power-down changed configuration");

   property p_horiz;
      @(posedge clk_i) disable iff (!rst_n)
      (wr_acc && paddr_i == DATA_OFS && !vertical_reg &&
       bank_pointer_reg < BANK_ICON && col_reg != COL_LAST) |=>
         col_reg == $past(col_reg) + 7'h1 && $stable(bank_pointer_reg);
   endproperty
   a_horiz: assert property (p_horiz)
      else $error("horizontal step wrong");

   property p_vert;
      @(posedge clk_i) disable iff (!rst_n)
      (wr_acc && paddr_i == DATA_OFS && vertical_reg &&
       bank_pointer_reg < BANK_LAST) |=>
         bank_pointer_reg == $past(bank_pointer_reg) + 3'h1 &&
         $stable(col_reg);
   endproperty
   a_vert: assert property (p_vert)
      else $error("vertical step wrong");

   property p_icon;
      @(posedge clk_i) disable iff (!rst_n)
      (wr_acc && paddr_i == DATA_OFS && bank_pointer_reg == BANK_ICON) |=>
         bank_pointer_reg == BANK_ICON &&
         col_reg == $past(col_reg) + 7'h1;
   endproperty
   a_icon: assert property (p_icon)
      else $error("icon write moved off bank 5");

   property p_wrap;
      @(posedge clk_i) disable iff (!rst_n)
      (wr_acc && paddr_i == DATA_OFS && !vertical_reg &&
       col_reg == COL_LAST && bank_pointer_reg == BANK_LAST) |=>
         col_reg == 7'h0 && bank_pointer_reg == 3'h0;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("last address did not wrap to zero");

   property p_mux;
      @(posedge clk_i) disable iff (!rst_n)
      (wr_acc && paddr_i == CFG_OFS && pwdata_i[1:0] == MUX_26) |=>
         mux_duty_o == DUTY_26;
   endproperty
   a_mux: assert property (p_mux)
      else $error("1:26 duty not selected");

   property p_mult_rst;
      @(posedge clk_i)
      $rose(rst_n) |-> multiplier_factor_o == 3'h2 && power_down_flag_reg &&
                       !vertical_reg && drive_mv_o == 14'h0;
   endproperty
   a_mult_rst: assert property (p_mult_rst)
      else $error("reset state wrong");

endmodule

`default_nettype wire

// File: src/lcd_cfg_pkg.sv
// Purpose: Shared constants for the LCD driver configuration bank.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses; fields sit in the low bits.
package lcd_cfg_pkg;

   // Register byte offsets.
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] CFG_OFS    = 8'h04;
   localparam logic [7:0] VOLT_OFS   = 8'h08;
   localparam logic [7:0] PTR_OFS    = 8'h0c;
   localparam logic [7:0] DATA_OFS   = 8'h10;
   localparam logic [7:0] STAT_OFS   = 8'h14;

   // Control register field positions.
   localparam int PD_BIT     = 0;
   localparam int VERT_BIT   = 1;
   localparam int DISP_LSB   = 2;
   localparam int ICON_BIT   = 4;

   // Configuration register field positions.
   localparam int MUX_LSB    = 0;
   localparam int BIAS_LSB   = 2;
   localparam int TC_LSB     = 5;
   localparam int MULT_LSB   = 8;
   localparam int HVE_BIT    = 10;
   localparam int PRS_BIT    = 11;
   localparam int PAGE_LSB   = 12;

   // Pointer register field positions.
   localparam int COL_LSB    = 0;
   localparam int BANK_LSB   = 8;

   // Pointer limits and the icon bank.
   localparam logic [6:0] COL_LAST   = 7'h7f;
   localparam logic [2:0] BANK_LAST  = 3'h4;
   localparam logic [2:0] BANK_ICON  = 3'h5;

   // Multiplex encodings and the duty each one gives.
   localparam logic [1:0] MUX_17     = 2'h0;
   localparam logic [1:0] MUX_26     = 2'h2;
   localparam logic [1:0] MUX_34     = 2'h1;
   localparam logic [5:0] DUTY_17    = 6'h11;
   localparam logic [5:0] DUTY_26    = 6'h1a;
   localparam logic [5:0] DUTY_34    = 6'h22;

   // Drive voltage in millivolts: offset per range plus step per code.
   localparam logic [13:0] VLO_MV    = 14'h0b7c;
   localparam logic [13:0] VHI_MV    = 14'h1a5e;
   localparam logic [6:0]  VSTEP_MV  = 7'h1e;

   // Multiplier factor base: field value zero gives two times.
   localparam logic [2:0] MULT_BASE  = 3'h2;
   localparam logic [2:0] BIAS_TOP   = 3'h7;

   // Reset values.
   localparam logic       PD_RST     = 1'b1;
   localparam logic [6:0] VOLT_RST   = 7'h00;

endpackage

// File: dv/apb_host_model.sv
// Purpose: APB host that drives register traffic into the bank.
// Assumes: Signals change by non-blocking assignment after a rising edge.
// Notes:   Waits for pready, so any number of wait states is accepted.
`timescale 1ns/1ps
`default_nettype none
module apb_host_model
(
   input  wire logic        clk_i,
   input  wire logic        pready_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic      [7:0]  paddr_o,
   output logic      [31:0] pwdata_o
);
   // Bus idles with no request at time zero.
   initial
   begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
   end
   // Setup cycle, then access held until pready is seen high.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
   begin
      @(posedge clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do @(posedge clk_i); while (pready_i !== 1'b1);
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwdata_o <= ~d; // Stale data must not look valid.
   end
   endtask
endmodule
`default_nettype wire

// File: dv/lcd_driver_config_tb.sv
// Purpose: Self-checking bench for the LCD configuration bank.
// Assumes: Zero or more wait states; reads checked from a queue.
// Notes:   RAM strobes are checked as {bank, column, byte} notes.
`timescale 1ns/1ps
`default_nettype none
module lcd_driver_config_tb;
   import lcd_cfg_pkg::*;
   logic        clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o;
   logic        pslverr_o, lcd_grounded_o, osc_enable_o, icon_only_o;
   logic        por_detect_enable_o, ram_we_o, hv_enable_o;
   logic [7:0]  paddr_i, ram_data_o;
   logic [31:0] pwdata_i, prdata_o, r, v;
   logic [6:0]  ram_col_o;
   logic [2:0]  ram_bank_o, bias_n_o, temp_coefficient_o;
   logic [2:0]  multiplier_factor_o;
   logic [5:0]  mux_duty_o;
   logic [1:0]  display_mode_o, cmd_page_o;
   logic [13:0] drive_mv_o;
   logic [5:0]  duty [4] = '{6'h11, 6'h22, 6'h1a, 6'h11};
   logic [31:0] qd[$];
   logic [17:0] qr[$];
   int          n_fail = 0, comparisons = 0, cyc = 0;

   lcd_driver_config lcd_driver_config_inst
   (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .lcd_grounded_o,
    .osc_enable_o, .por_detect_enable_o, .ram_we_o, .ram_col_o,
    .ram_bank_o, .ram_data_o, .mux_duty_o, .display_mode_o,
    .icon_only_o, .bias_n_o, .temp_coefficient_o, .multiplier_factor_o,
    .hv_enable_o, .drive_mv_o, .cmd_page_o);
   apb_host_model apb_host_model_inst
   (.clk_i, .pready_i(pready_o), .psel_o(psel_i), .penable_o(penable_i),
    .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
   begin
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time,
                  seen, exp);
      end
   end
   endtask
   task automatic complete_run();
   begin
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb_host_model_inst.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
   begin
      qd.push_back(e);
      apb_host_model_inst.xfer(1'b0, a, 32'h0);
   end
   endtask
   // Two data bytes from a start pointer; notes where each must land.
   task automatic two(input logic [31:0] ctl, input logic [31:0] ptr,
                      input logic [9:0] p0, input logic [9:0] p1);
   begin
      wr(CTRL_OFS, ctl);
      wr(PTR_OFS, ptr);
      qr.push_back({p0, 8'($urandom)});
      wr(DATA_OFS, {24'h0, qr[$][7:0]});
      qr.push_back({p1, 8'($urandom)});
      wr(DATA_OFS, {24'h0, qr[$][7:0]});
      @(negedge clk_i);
   end
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // Watcher: pairs each read answer and RAM strobe with the oldest note.
   always @(posedge clk_i)
   begin
      cyc++;
      if (psel_i && penable_i && pready_o && !pwrite_i && qd.size() > 0)
         chk(prdata_o, qd.pop_front());
      if (ram_we_o === 1'b1)
         chk({ram_bank_o, ram_col_o, ram_data_o}, qr.pop_front());
      if (cyc == 4000)
      begin
         n_fail++;
         complete_run();
      end
   end

   initial
   begin
      rst_b_i = 1'b0;
      void'($urandom(36585));
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(CTRL_OFS, 32'h1);
      rd(CFG_OFS, 32'h0);
      rd(STAT_OFS, 32'h11ea);
      chk({lcd_grounded_o, osc_enable_o, por_detect_enable_o}, 3'h5);
      $display("test reset done");
      // Host keeps the high range at or below 9000 mV.
      v = $urandom % 76;
      r = $urandom & 32'h3fff;
      wr(VOLT_OFS, v);
      wr(CFG_OFS, r);
      rd(CFG_OFS, r);
      wr(CTRL_OFS, 32'h0);
      rd(CFG_OFS, r);
      @(negedge clk_i);
      chk({lcd_grounded_o, osc_enable_o}, 2'h1);
      chk(bias_n_o, 3'h7 - r[4:2]);
      chk(multiplier_factor_o, 3'h2 + r[9:8]);
      chk({cmd_page_o, hv_enable_o, temp_coefficient_o},
          {r[13:12], r[10], r[7:5]});
      chk(drive_mv_o, r[10] ? (r[11] ? 6750 : 2940) + 30 * v : 0);
      $display("test power-down and fields done");
      two(32'h1d, 32'h203, {3'h2, 7'h03}, {3'h2, 7'h04});
      chk({display_mode_o, icon_only_o}, 3'h7);
      two(32'h1, 32'h47f, {3'h4, 7'h7f}, 10'h0);
      two(32'h3, 32'h305, {3'h3, 7'h05}, {3'h4, 7'h05});
      two(32'h3, 32'h405, {3'h4, 7'h05}, {3'h0, 7'h06});
      two(32'h3, 32'h57f, {3'h5, 7'h7f}, {3'h5, 7'h00});
      two(32'h1, 32'h67f, {3'h5, 7'h7f}, {3'h5, 7'h00});
      $display("test pointers done");
      for (int i = 0; i < 4; i++)
      begin
         wr(CFG_OFS, i);
         @(negedge clk_i);
         chk(mux_duty_o, duty[i]);
      end
      rd(8'h18, 32'h0);
      @(negedge clk_i);
      chk(pslverr_o, 1'b1);
      $display("test multiplex and unmapped done");
      complete_run();
   end
endmodule
`default_nettype wire
